//--- logic/cxp_pkg.sv
package cxp_pkg;
  // Clock and timing
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned RSTO_NS = 2048;
  localparam int unsigned RSTO_CYC = (RSTO_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RSTO_W = 10;
  // Status word field positions and reset values
  localparam int unsigned SR_T1 = 15;
  localparam int unsigned SR_T0 = 14;
  localparam int unsigned SR_S = 13;
  localparam int unsigned SR_IPM_LSB = 8;
  localparam logic [2:0] IPM_MAX = 3'h7;
  localparam logic [15:0] SR_RST = 16'h2700;
  localparam logic [31:0] VBR_RST = 32'h00000000;
  // Vector table and CPU space locations
  localparam logic [31:0] RVEC_SP_ADDR = 32'h00000000;
  localparam logic [31:0] RVEC_PC_ADDR = 32'h00000004;
  localparam logic [31:0] HWBK_ADDR = 32'h0000001E;
  localparam logic [7:0] VEC_HWBK = 8'h0C;
  localparam logic [15:0] SWBK_LO = 16'h4848;
  localparam logic [15:0] SWBK_HI = 16'h484F;
  // Stack frame format codes
  localparam logic [3:0] FMT_4W = 4'h0;
  localparam logic [3:0] FMT_6W = 4'h2;
  localparam logic [3:0] FMT_BUS = 4'hC;
  // Special status word field positions
  localparam int unsigned SSW_FC = 0;
  localparam int unsigned SSW_SZ = 3;
  localparam int unsigned SSW_RD = 5;
  localparam int unsigned SSW_PF = 6;
  localparam logic [1:0] SZ_LONG = 2'h0;
  // Register offsets
  localparam logic [7:0] OFS_STAT = 8'h00;
  localparam logic [7:0] OFS_VBR = 8'h04;
  localparam logic [7:0] OFS_SR = 8'h08;
  localparam logic [7:0] OFS_PC = 8'h0C;
  localparam logic [7:0] OFS_ISP = 8'h10;
  // Status register field positions
  localparam int unsigned STB_ST = 0;
  localparam int unsigned STB_HALT = 4;
  localparam int unsigned STB_CRIT = 5;
  localparam int unsigned STB_TPEND = 6;
  localparam int unsigned STB_HWP = 7;
  localparam int unsigned STB_RSTO = 8;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_RST, ST_RUN, ST_PUSH, ST_VEC, ST_SWBK, ST_HWBK, ST_HALT
  } cxp_st_t;
endpackage : cxp_pkg

//--- logic/cxp_exc_unit.sv
`timescale 1ns/10ps
module cxp_exc_unit
  import cxp_pkg::*;
#(
  parameter logic [7:0] VEC_BUS_ERROR_LINE = 8'h02, // Plain default
  parameter logic [7:0] VEC_AERR = 8'h03, // Plain default
  parameter logic [7:0] VEC_ILL = 8'h04, // Plain default
  parameter logic [7:0] VEC_TRACE = 8'h09, // Plain default
  parameter logic [7:0] VEC_TRAP0 = 8'h20 // Plain default
) (
  input wire logic mclk, // Clock
  input wire logic rst, // Sync reset
  input wire logic ce, // Clock enable
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic bus_error_pin, // External bus error pin
  input wire logic bus_error_int, // Internal module bus error
  input wire logic wdog_timeout, // Watchdog no-response
  input wire logic data_size_ack, // Cycle ack pin
  input wire logic [31:0] bus_rdata, // Read data
  output logic bus_req, // Cycle request
  output logic bus_wr, // Cycle is write
  output logic bus_cpu_space, // CPU space cycle
  output logic [31:0] bus_addr, // Cycle address
  output logic [31:0] bus_wdata, // Write data
  input wire logic data_fault, // Aborted data access
  input wire logic fault_wr, // Faulted access is write
  input wire logic [1:0] fault_size, // Faulted access size
  input wire logic [2:0] fault_fc, // Faulted function code
  input wire logic [31:0] fault_addr, // Faulted address
  input wire logic pf_fault, // Aborted prefetch
  input wire logic pf_used, // Prefetched word used
  input wire logic pf_flush, // Prefetch queue flushed
  input wire logic relw_fault, // Released write faulted
  input wire logic insn_bnd, // Instruction boundary
  input wire logic opnd_acc, // Operand access attempt
  input wire logic odd_acc, // Odd fetch or operand
  input wire logic br_odd, // Taken branch, odd target
  input wire logic [31:0] br_target, // Branch target
  input wire logic rte_load, // Loading return frame
  input wire logic [31:0] insn_pc, // Current instruction
  input wire logic [31:0] next_pc, // Following instruction
  input wire logic trap_req, // Trap condition met
  input wire logic trap_uncond, // Unconditional trap
  input wire logic [3:0] trap_num, // Trap opcode number
  input wire logic [7:0] trap_vec, // Other trap vector
  input wire logic op_exec, // Opcode executes
  input wire logic [15:0] opcode, // Executing opcode
  input wire logic reset_op, // Reset instruction
  input wire logic hw_bkpt_req, // Hardware breakpoint
  input wire logic insn_bkpt_req, // Instruction breakpoint
  input wire logic insn_done, // Instruction executed
  output logic halted, // Halted indicator
  output logic reset_out, // Peripheral reset
  output logic [31:0] program_counter, // Program counter
  output logic pc_load, // New PC pulse
  output logic [31:0] interrupt_stack_pointer, // Stack pointer
  output logic [15:0] status_word_reg, // Status word
  output logic ea_restore, // Restore EA registers
  output logic [15:0] repl_op, // Replacement opcode
  output logic repl_valid // Replacement pulse
);
  cxp_st_t st_ff;
  logic bus_error_line_m_ff, bus_error_line_s_ff, ack_m_ff, ack_s_ff;
  logic pready_ff, pslverr_ff;
  logic [31:0] prdata_ff, rd_mux;
  logic rd_hit;
  logic [15:0] sr_ff;
  logic [31:0] vbr_ff, isp_ff, pc_ff;
  logic [31:0] bus_addr_ff, bus_wdata_ff;
  logic bus_req_ff, bus_wr_ff, bus_cpu_ff;
  logic halted_ff, crit_ff, tpend_ff, pc_load_ff, ea_rest_ff, repl_ff;
  logic pf_fault_ff, relw_ff, ibk_ff, hwp_ff, rso_ff;
  logic [RSTO_W-1:0] rso_cnt_ff;
  logic [15:0] repl_op_ff;
  logic [7:0] vec_ff;
  logic [2:0] step_ff, n_ff;
  logic [31:0] fr_ff [4];
  logic apb_wr;
  logic bus_error_line_ln, bus_ok, bus_bad, pf_hit, relw_hit;
  logic aerr_now, bus_error_line_now, bus_error_line_any, flt_now, go_halt, go_ex, hw_go, sw_go;
  logic s_crit, s_trap, s_trace;
  logic [7:0] s_vec;
  logic [2:0] s_n;
  logic [31:0] s_fr [4];
  logic [31:0] s_pc;
  logic [15:0] s_vo, s_ssw;

  // Two-flop capture of external pins
  always_ff @(posedge mclk) begin : pin_sync
    if (rst) begin
      bus_error_line_m_ff <= 1'b0;
      bus_error_line_s_ff <= 1'b0;
      ack_m_ff <= 1'b0;
      ack_s_ff <= 1'b0;
    end else if (ce) begin
      bus_error_line_m_ff <= bus_error_pin;
      bus_error_line_s_ff <= bus_error_line_m_ff;
      ack_m_ff <= data_size_ack;
      ack_s_ff <= ack_m_ff;
    end
  end

  // Bus error line and cycle termination
  // three error sources
  assign bus_error_line_ln = bus_error_line_s_ff | bus_error_int | wdog_timeout;
  assign bus_ok = bus_req_ff & ack_s_ff & ~bus_error_line_ln;
  assign bus_bad = bus_req_ff & bus_error_line_ln;
  assign pf_hit = pf_used & pf_fault_ff;
  assign relw_hit = relw_ff & (insn_bnd | opnd_acc);
  assign aerr_now = odd_acc | br_odd;
  assign bus_error_line_now = data_fault | pf_hit | relw_hit;
  assign bus_error_line_any = bus_error_line_now | (bus_bad & (st_ff == ST_PUSH || st_ff == ST_VEC));
  assign flt_now = aerr_now | bus_error_line_now | bus_bad;
  assign go_halt = (st_ff != ST_HALT) & ((crit_ff & flt_now) | (rte_load & bus_error_line_now));

  // Exception selection and frame build
  always_comb begin : ex_select
    s_pc = insn_pc;
    go_ex = 1'b0;
    s_crit = 1'b0;
    s_trap = 1'b0;
    s_trace = 1'b0;
    s_vec = VEC_BUS_ERROR_LINE;
    s_n = 3'h2;
    s_vo = {FMT_4W, 2'b00, VEC_BUS_ERROR_LINE, 2'b00};
    s_ssw = '0;
    s_ssw[SSW_FC +: 3] = fault_fc;
    s_ssw[SSW_SZ +: 2] = fault_size;
    s_ssw[SSW_RD] = ~fault_wr;
    s_ssw[SSW_PF] = pf_hit;
    s_fr[0] = fault_addr;
    if (!go_halt && st_ff != ST_HALT && st_ff != ST_RST) begin
      if (aerr_now || bus_error_line_any) begin
        go_ex = 1'b1;
        s_crit = 1'b1;
        s_n = 3'h4;
        s_vec = aerr_now ? VEC_AERR : VEC_BUS_ERROR_LINE;
        if (br_odd) begin
          s_fr[0] = br_target;
          s_pc = br_target;
        end else if (bus_bad && !bus_error_line_now && !aerr_now) begin
          s_fr[0] = bus_addr_ff;
          s_ssw[SSW_SZ +: 2] = SZ_LONG;
          s_ssw[SSW_RD] = ~bus_wr_ff;
        end
      end else if (st_ff == ST_SWBK && bus_bad) begin
        go_ex = 1'b1;
        s_vec = VEC_ILL;
      end else if (st_ff == ST_HWBK && bus_bad) begin
        go_ex = 1'b1;
        s_vec = VEC_HWBK;
        s_n = 3'h3;
        s_fr[0] = insn_pc;
        s_pc = next_pc;
      end else if (st_ff == ST_RUN && trap_req) begin
        go_ex = 1'b1;
        s_trap = 1'b1;
        s_pc = next_pc;
        s_fr[0] = insn_pc;
        s_vec = trap_uncond ? VEC_TRAP0 + {4'h0, trap_num} : trap_vec;
        s_n = trap_uncond ? 3'h2 : 3'h3;
      end else if (st_ff == ST_VEC && bus_ok && tpend_ff) begin
        go_ex = 1'b1;
        s_trace = 1'b1;
        s_vec = VEC_TRACE;
        s_n = 3'h3;
        s_fr[0] = insn_pc;
        s_pc = next_pc;
      end
    end
    unique case (s_n)
      3'h4: s_vo = {FMT_BUS, 2'b00, s_vec, 2'b00};
      3'h3: s_vo = {FMT_6W, 2'b00, s_vec, 2'b00};
      default: s_vo = {FMT_4W, 2'b00, s_vec, 2'b00};
    endcase
    if (s_n == 3'h4) begin
      s_fr[1] = {16'h0000, s_ssw};
      s_fr[2] = {s_pc[15:0], s_vo};
      s_fr[3] = {sr_ff, s_pc[31:16]};
    end else if (s_n == 3'h3) begin
      s_fr[1] = {s_pc[15:0], s_vo};
      s_fr[2] = {sr_ff, s_pc[31:16]};
      s_fr[3] = '0;
    end else begin
      s_fr[0] = {s_pc[15:0], s_vo};
      s_fr[1] = {sr_ff, s_pc[31:16]};
      s_fr[2] = '0;
      s_fr[3] = '0;
    end
  end

  // Breakpoint cycle starts
  // hardware acknowledge at boundary or exception end, software on opcode execute in run
  assign hw_go = hwp_ff & ~go_halt & ~go_ex &
                 ((st_ff == ST_RUN & insn_bnd) | (st_ff == ST_VEC & bus_ok));
  assign sw_go = (st_ff == ST_RUN) & ~go_halt & ~go_ex & ~hw_go & op_exec &
                 (opcode >= SWBK_LO) & (opcode <= SWBK_HI);

  // Main exception sequencer
  always_ff @(posedge mclk) begin : seq
    if (rst) begin
      st_ff <= ST_RST;
      step_ff <= '0;
      n_ff <= '0;
      crit_ff <= 1'b1;
      halted_ff <= 1'b0;
      bus_req_ff <= 1'b1;
      bus_wr_ff <= 1'b0;
      bus_cpu_ff <= 1'b0;
      bus_addr_ff <= RVEC_SP_ADDR;
      bus_wdata_ff <= '0;
      isp_ff <= '0;
      pc_ff <= '0;
      pc_load_ff <= 1'b0;
      vec_ff <= '0;
      tpend_ff <= 1'b0;
      repl_ff <= 1'b0;
      repl_op_ff <= '0;
      ea_rest_ff <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        fr_ff[i] <= '0;
      end
    end else if (ce) begin
      pc_load_ff <= 1'b0;
      repl_ff <= 1'b0;
      ea_rest_ff <= 1'b0;
      if (go_halt) begin
        st_ff <= ST_HALT;
        halted_ff <= 1'b1;
        bus_req_ff <= 1'b0;
      end else if (go_ex) begin
        vec_ff <= s_vec;
        n_ff <= s_n;
        fr_ff <= s_fr;
        step_ff <= 3'h1;
        crit_ff <= s_crit;
        ea_rest_ff <= s_crit;
        if (s_trap) begin
          tpend_ff <= sr_ff[SR_T1] | sr_ff[SR_T0];
        end else if (s_trace) begin
          tpend_ff <= 1'b0;
        end
        if (st_ff == ST_VEC && bus_ok) begin
          pc_ff <= bus_rdata;
          pc_load_ff <= 1'b1;
        end
        bus_req_ff <= 1'b1;
        bus_wr_ff <= 1'b1;
        bus_cpu_ff <= 1'b0;
        bus_addr_ff <= isp_ff - 32'h4;
        bus_wdata_ff <= s_fr[0];
        isp_ff <= isp_ff - 32'h4;
        st_ff <= ST_PUSH;
      end else if (hw_go || sw_go) begin
        if (st_ff == ST_VEC) begin
          pc_ff <= bus_rdata;
          pc_load_ff <= 1'b1;
          crit_ff <= 1'b0;
        end
        bus_req_ff <= 1'b1;
        bus_wr_ff <= 1'b0;
        bus_cpu_ff <= 1'b1;
        bus_addr_ff <= hw_go ? HWBK_ADDR : {27'h0, opcode[2:0], 2'b00};
        st_ff <= hw_go ? ST_HWBK : ST_SWBK;
      end else begin
        unique case (st_ff)
          ST_RST: begin
            if (bus_ok && step_ff == 3'h0) begin
              isp_ff <= bus_rdata;
              bus_addr_ff <= RVEC_PC_ADDR;
              step_ff <= 3'h1;
            end else if (bus_ok) begin
              pc_ff <= bus_rdata;
              pc_load_ff <= 1'b1;
              bus_req_ff <= 1'b0;
              crit_ff <= 1'b0;
              st_ff <= ST_RUN;
            end
          end
          ST_PUSH: begin
            if (bus_ok && step_ff == n_ff) begin
              bus_wr_ff <= 1'b0;
              bus_addr_ff <= vbr_ff + {22'h0, vec_ff, 2'b00};
              st_ff <= ST_VEC;
            end else if (bus_ok) begin
              bus_addr_ff <= isp_ff - 32'h4;
              bus_wdata_ff <= fr_ff[step_ff[1:0]];
              isp_ff <= isp_ff - 32'h4;
              step_ff <= step_ff + 3'h1;
            end
          end
          ST_VEC: begin
            if (bus_ok) begin
              pc_ff <= bus_rdata;
              pc_load_ff <= 1'b1;
              crit_ff <= 1'b0;
              bus_req_ff <= 1'b0;
              st_ff <= ST_RUN;
            end
          end
          ST_SWBK: begin
            if (bus_ok) begin
              repl_op_ff <= bus_rdata[15:0];
              repl_ff <= 1'b1;
              bus_req_ff <= 1'b0;
              st_ff <= ST_RUN;
            end
          end
          ST_HWBK: begin
            if (bus_ok) begin
              bus_req_ff <= 1'b0;
              st_ff <= ST_RUN;
            end
          end
          ST_RUN, ST_HALT: begin
          end
        endcase
      end
    end
  end

  // Deferred fault and breakpoint flags, set wins over clear
  always_ff @(posedge mclk) begin : pend
    if (rst) begin
      pf_fault_ff <= 1'b0;
      relw_ff <= 1'b0;
      ibk_ff <= 1'b0;
      hwp_ff <= 1'b0;
    end else if (ce) begin
      pf_fault_ff <= pf_fault | (pf_fault_ff & ~pf_flush & ~pf_hit);
      relw_ff <= relw_fault | (relw_ff & ~relw_hit);
      ibk_ff <= insn_bkpt_req | (ibk_ff & ~insn_done);
      hwp_ff <= hw_bkpt_req | (ibk_ff & insn_done) | (hwp_ff & ~hw_go);
    end
  end

  // Status word and vector base
  always_ff @(posedge mclk) begin : sregs
    if (rst) begin
      sr_ff <= SR_RST;
      vbr_ff <= VBR_RST;
    end else if (ce) begin
      if (go_ex) begin
        sr_ff[SR_T1] <= 1'b0;
        sr_ff[SR_T0] <= 1'b0;
        sr_ff[SR_S] <= 1'b1;
      end else if (apb_wr && paddr == OFS_SR) begin
        sr_ff <= pwdata[15:0];
      end
      if (apb_wr && paddr == OFS_VBR) begin
        vbr_ff <= pwdata;
      end
    end
  end

  // Peripheral reset pulse timer
  always_ff @(posedge mclk) begin : rsto
    if (rst) begin
      rso_ff <= 1'b0;
      rso_cnt_ff <= '0;
    end else if (ce) begin
      if (reset_op && st_ff == ST_RUN && !rso_ff) begin
        rso_ff <= 1'b1;
        rso_cnt_ff <= '0;
      end else if (rso_ff) begin
        rso_cnt_ff <= rso_cnt_ff + 1'b1;
        rso_ff <= rso_cnt_ff != RSTO_W'(RSTO_CYC - 1);
      end
    end
  end

  // APB read mux
  always_comb begin : rdmux
    rd_mux = '0;
    rd_hit = 1'b1;
    unique case (paddr)
      OFS_STAT: begin
        rd_mux[STB_ST +: 3] = st_ff;
        rd_mux[STB_HALT] = halted_ff;
        rd_mux[STB_CRIT] = crit_ff;
        rd_mux[STB_TPEND] = tpend_ff;
        rd_mux[STB_HWP] = hwp_ff;
        rd_mux[STB_RSTO] = rso_ff;
      end
      OFS_VBR: rd_mux = vbr_ff;
      OFS_SR: rd_mux[15:0] = sr_ff;
      OFS_PC: rd_mux = pc_ff;
      OFS_ISP: rd_mux = isp_ff;
      default: rd_hit = 1'b0;
    endcase
  end

  // APB slave with one wait state
  assign apb_wr = psel & penable & pready_ff & pwrite & rd_hit;
  always_ff @(posedge mclk) begin : apb
    if (rst) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end else if (ce) begin
      pready_ff <= psel & penable & ~pready_ff;
      pslverr_ff <= psel & penable & ~pready_ff & ~rd_hit;
      prdata_ff <= (psel & penable & ~pready_ff & ~pwrite) ? rd_mux : '0;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign bus_req = bus_req_ff;
  assign bus_wr = bus_wr_ff;
  assign bus_cpu_space = bus_cpu_ff;
  assign bus_addr = bus_addr_ff;
  assign bus_wdata = bus_wdata_ff;
  assign halted = halted_ff;
  assign reset_out = rso_ff;
  assign program_counter = pc_ff;
  assign pc_load = pc_load_ff;
  assign interrupt_stack_pointer = isp_ff;
  assign status_word_reg = sr_ff;
  assign ea_restore = ea_rest_ff;
  assign repl_op = repl_op_ff;
  assign repl_valid = repl_ff;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_reset_sr_vbr: assert property ($past(rst) |-> sr_ff == SR_RST && vbr_ff == VBR_RST)
    else $error("reset state wrong");
  a_reset_pc_load: assert property (st_ff == ST_RST && bus_ok && step_ff == 3'h1 && ce && !go_halt
    |=> pc_load_ff && pc_ff == $past(bus_rdata) && st_ff == ST_RUN)
    else $error("reset pc load wrong");
  a_reset_no_push: assert property (st_ff == ST_RST |-> !bus_wr_ff)
    else $error("reset wrote stack");
  a_double_halt: assert property (crit_ff && flt_now && st_ff != ST_HALT && ce |=> halted_ff)
    else $error("double fault not halted");
  a_halt_held: assert property (st_ff == ST_HALT |=> st_ff == ST_HALT && halted_ff && !bus_req_ff)
    else $error("left halt");
  a_rsto_pulse: assert property (reset_op && st_ff == ST_RUN && !rso_ff && ce && !go_ex
    |=> rso_ff && isp_ff == $past(isp_ff))
    else $error("reset instruction wrong");
  a_pf_flush: assert property (pf_fault_ff && pf_flush && !pf_fault && ce |=> !pf_fault_ff)
    else $error("flushed fault kept");
  a_relw_fire: assert property (relw_hit && st_ff == ST_RUN && !aerr_now && !crit_ff && !rte_load && ce
    |=> st_ff == ST_PUSH && vec_ff == VEC_BUS_ERROR_LINE && ea_rest_ff)
    else $error("released write fault lost");
  a_trace_after: assert property (st_ff == ST_VEC && bus_ok && tpend_ff && !crit_ff && !aerr_now && !bus_error_line_now && ce
    |=> st_ff == ST_PUSH && vec_ff == VEC_TRACE)
    else $error("trace not after trap");
  a_hwbk_addr: assert property (st_ff == ST_HWBK |-> bus_cpu_ff && bus_addr_ff == HWBK_ADDR)
    else $error("breakpoint ack address");
  a_swbk_repl: assert property (st_ff == ST_SWBK && bus_ok && ce && !go_ex && !go_halt
    |=> repl_ff && repl_op_ff == $past(bus_rdata[15:0]))
    else $error("replacement opcode wrong");
  c_reset_done: cover property (st_ff == ST_RST ##[1:20] st_ff == ST_RUN);
  c_halt: cover property (st_ff != ST_HALT ##1 st_ff == ST_HALT);
  c_hwbk_err: cover property (st_ff == ST_HWBK && bus_bad);
  c_swbk_ok: cover property (repl_ff);
endmodule : cxp_exc_unit

//--- verif/cxp_bus_model.sv
`timescale 1ns/10ps
module cxp_bus_model #(
  parameter logic [31:0] SP_V = 32'h00001000, // Reset stack word
  parameter logic [31:0] PC_V = 32'h00000400 // Reset start word
) (
  input wire logic mclk, // Clock
  input wire logic rst, // Sync reset
  input wire logic bus_req, // Cycle request
  input wire logic bus_cpu_space, // CPU space cycle
  input wire logic [31:0] bus_addr, // Cycle address
  input wire logic err_all, // Fail every cycle
  input wire logic err_cpu, // Fail CPU space cycles
  input wire logic slow, // Long response delay
  output logic data_size_ack, // Normal termination
  output logic bus_error_pin, // Error termination
  output logic [31:0] bus_rdata // Read data
);
  logic [3:0] cnt_ff;
  logic [31:0] data_ff;
  // Data stands only in the hold window, else the inverse of it
  assign bus_rdata = (cnt_ff != 4'h0 && cnt_ff < 4'h7) ? data_ff : ~data_ff;
  // Wait, give one terminating pulse, then hold data past the pin synchroniser
  always_ff @(posedge mclk) begin
    data_size_ack <= 1'h0;
    bus_error_pin <= 1'h0;
    if (rst) begin
      cnt_ff <= 4'h0;
      data_ff <= 32'h0;
    end else if (cnt_ff != 4'h0) begin
      cnt_ff <= cnt_ff - 4'h1;
    end else if (bus_req) begin
      cnt_ff <= slow ? 4'hC : 4'h7;
    end
    if (!rst && cnt_ff == 4'h7) begin
      data_ff <= (bus_addr == 32'h0 && !bus_cpu_space) ? SP_V :
                 (bus_addr == 32'h4 && !bus_cpu_space) ? PC_V : {2{bus_addr[15:0]}};
      bus_error_pin <= err_all || (err_cpu && bus_cpu_space);
      data_size_ack <= !(err_all || (err_cpu && bus_cpu_space));
    end
  end
endmodule : cxp_bus_model

//--- verif/test_cpu_exception_processing.sv
`timescale 1ns/10ps
module test_cpu_exception_processing;
  import cxp_pkg::*;
  localparam logic [31:0] SPV = 32'h00001000;
  localparam logic [31:0] PCV = 32'h00000400;
  logic mclk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic err_all = 1'h0, err_cpu = 1'h0, slow = 1'h0, e;
  logic [12:0] pv = 13'h0;
  logic [3:0] lv = 4'h0;
  logic [1:0] fault_size = 2'h0;
  logic [2:0] fault_fc = 3'h0;
  logic [3:0] trap_num = 4'h0;
  logic [7:0] paddr = 8'h0, trap_vec = 8'h0;
  logic [15:0] opcode = 16'h0, status_word_reg, repl_op;
  logic [31:0] pwdata = 32'h0, fault_addr = 32'h0, insn_pc = 32'h0, next_pc = 32'h0;
  logic [31:0] prdata, bus_addr, bus_rdata, program_counter, r, pc0, isp, bus_wdata, wd;
  logic [31:0] cs_addr = 32'hFFFFFFFF;
  logic pready, pslverr, bus_req, bus_cpu_space, halted, reset_out, pc_load, repl_valid;
  logic data_size_ack, bus_error_pin, bus_wr, ea_restore;
  int err_count = 0, checked = 0, cyc = 0, ea_n = 0;
  // Rows: write, offset, data, error
  logic [41:0] rows [7] = '{{1'h0, OFS_VBR, VBR_RST, 1'h0}, {1'h0, OFS_SR, 16'h0, SR_RST, 1'h0},
    {1'h0, OFS_PC, PCV, 1'h0}, {1'h0, OFS_ISP, SPV, 1'h0}, {1'h1, OFS_PC, 32'h00001234, 1'h0},
    {1'h0, OFS_PC, PCV, 1'h0}, {1'h0, 8'h14, 32'h0, 1'h1}};
  cxp_exc_unit i_cxp_exc_unit (
    .mclk(mclk), .rst(rst), .ce(1'h1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_error_pin(bus_error_pin),
    .bus_error_int(lv[0]), .wdog_timeout(lv[1]), .data_size_ack(data_size_ack), .bus_rdata(bus_rdata),
    .bus_req(bus_req), .bus_wr(bus_wr), .bus_cpu_space(bus_cpu_space), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .data_fault(pv[6]), .fault_wr(lv[2]), .fault_size(fault_size), .fault_fc(fault_fc),
    .fault_addr(fault_addr), .pf_fault(pv[7]), .pf_used(pv[8]), .pf_flush(pv[9]), .relw_fault(pv[10]),
    .insn_bnd(pv[1]), .opnd_acc(pv[11]), .odd_acc(pv[4]), .br_odd(pv[12]), .br_target(fault_addr),
    .rte_load(1'h0), .insn_pc(insn_pc), .next_pc(next_pc), .trap_req(pv[2]), .trap_uncond(lv[3]),
    .trap_num(trap_num), .trap_vec(trap_vec), .op_exec(pv[3]), .opcode(opcode), .reset_op(pv[5]),
    .hw_bkpt_req(pv[0]), .insn_bkpt_req(1'h0), .insn_done(1'h0), .halted(halted), .reset_out(reset_out),
    .program_counter(program_counter), .pc_load(pc_load), .interrupt_stack_pointer(isp),
    .status_word_reg(status_word_reg), .ea_restore(ea_restore), .repl_op(repl_op), .repl_valid(repl_valid));
  cxp_bus_model #(.SP_V(SPV), .PC_V(PCV)) i_cxp_bus_model (
    .mclk(mclk), .rst(rst), .bus_req(bus_req), .bus_cpu_space(bus_cpu_space), .bus_addr(bus_addr),
    .err_all(err_all), .err_cpu(err_cpu), .slow(slow), .data_size_ack(data_size_ack),
    .bus_error_pin(bus_error_pin), .bus_rdata(bus_rdata));
  // Clock, cycle ceiling and CPU space address capture
  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      wrap_up();
    end
  end
  always @(posedge mclk) if (bus_req === 1'h1 && bus_cpu_space === 1'h1) cs_addr <= bus_addr;
  // Last stacked word and count of fault entries
  always @(posedge mclk) if (bus_req === 1'h1 && bus_wr === 1'h1) wd <= bus_wdata;
  always @(posedge mclk) if (ea_restore === 1'h1) ea_n++;
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick
  // One-cycle pulse on a strobe input
  task pulse(input int k);
    @(posedge mclk);
    pv <= 13'h1 << k;
    @(posedge mclk);
    pv <= 13'h0;
  endtask : pulse
  task wait_pc(output logic [31:0] pc);
    do @(posedge mclk); while (pc_load !== 1'h1);
    pc = program_counter;
  endtask : wait_pc
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] rd, output logic er);
    @(posedge mclk);
    psel <= 1'h1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    do @(posedge mclk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task wrap_up;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up
  // Main sequence
  initial begin
    tick(16);
    rst <= 1'h0;
    wait_pc(r);
    chk(r, PCV);
    chk(status_word_reg, SR_RST);
    chk(isp, SPV);
    for (int i = 0; i < 7; i++) begin
      apb(rows[i][40:33], rows[i][41], rows[i][32:1], r, e);
      if (!rows[i][41]) chk(r, rows[i][32:1]);
      chk(e, rows[i][0]);
    end
    $display("test reset and registers done");
    pc0 = program_counter;
    pulse(0);
    tick(20);
    chk(cs_addr, 32'hFFFFFFFF);
    pulse(1);
    tick(40);
    chk(cs_addr, HWBK_ADDR);
    chk(program_counter, pc0);
    err_cpu <= 1'h1;
    pulse(0);
    pulse(1);
    wait_pc(r);
    chk(r, 32'h00300030);
    opcode <= 16'h484A;
    pulse(3);
    wait_pc(r);
    chk(r, 32'h00100010);
    chk(cs_addr, 32'h8);
    err_cpu <= 1'h0;
    for (int n = 0; n < 8; n++) begin
      opcode <= 16'(SWBK_LO + n);
      pulse(3);
      do @(posedge mclk); while (repl_valid !== 1'h1);
      chk(repl_op, n * 4);
      chk(cs_addr, n * 4);
    end
    $display("test breakpoints done");
    apb(OFS_SR, 1'h1, 32'h0000A700, r, e);
    slow <= 1'h1;
    lv[3] <= 1'h1;
    trap_num <= 4'h3;
    pulse(2);
    wait_pc(r);
    chk(r, 32'h008C008C);
    wait_pc(r);
    chk(r, 32'h00240024);
    chk(status_word_reg[15:13], 3'h1);
    lv[3] <= 1'h0;
    trap_vec <= 8'h06;
    pulse(2);
    wait_pc(r);
    chk(r, 32'h00180018);
    slow <= 1'h0;
    fault_addr <= 32'h00000101;
    pulse(4);
    wait_pc(r);
    chk(r, 32'h000C000C);
    pulse(12);
    wait_pc(r);
    chk(r, 32'h000C000C);
    pulse(6);
    wait_pc(r);
    chk(r, 32'h00080008);
    chk(wd, 32'h27000000);
    chk(ea_n, 3);
    pc0 = program_counter;
    pulse(7);
    pulse(9);
    pulse(10);
    tick(30);
    chk(program_counter, pc0);
    pulse(1);
    wait_pc(r);
    chk(r, 32'h00080008);
    pulse(7);
    pulse(8);
    wait_pc(r);
    chk(r, 32'h00080008);
    $display("test traps and faults done");
    pc0 = program_counter;
    pulse(5);
    tick(10);
    chk(reset_out, 1'h1);
    tick(510);
    chk(reset_out, 1'h0);
    chk(program_counter, pc0);
    err_all <= 1'h1;
    rst <= 1'h1;
    tick(16);
    rst <= 1'h0;
    tick(100);
    chk(halted, 1'h1);
    chk(bus_req, 1'h0);
    err_all <= 1'h0;
    lv[1] <= 1'h1;
    rst <= 1'h1;
    tick(16);
    rst <= 1'h0;
    tick(4);
    chk(halted, 1'h1);
    lv[1] <= 1'h0;
    rst <= 1'h1;
    tick(16);
    rst <= 1'h0;
    wait_pc(r);
    chk(r, PCV);
    chk(halted, 1'h0);
    $display("test halt and restart done");
    wrap_up();
  end
endmodule : test_cpu_exception_processing
